// ### pkg/mie_pkg.sv
package mie_pkg;

    // Core widths
    localparam int DATA_W = 8;
    localparam int PC_W = 11;
    localparam int DMEM_ADDR_W = 7;
    localparam int PM_W = 16;
    localparam int STACK_DEPTH = 4;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ACC = 8'h08;
    localparam logic [7:0] OFS_PC = 8'h0c;
    localparam logic [7:0] OFS_TABLE_READ_HIGH_BYTE = 8'h10;

    // Field positions
    localparam int CTRL_GIE_BIT = 0;
    localparam int STATUS_HALT_BIT = 8;

    // Reset values
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [10:0] RST_PC = 11'h000;
    localparam logic RST_GIE = 1'b0;

    // Arithmetic constants
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_ADJ = 4'h6;
    localparam logic [2:0] LAST_PAGE = 3'h7;

    // Decoded operations, issued one per instruction
    typedef enum logic [5:0] {
        OP_NOP, OP_ADD, OP_ADC, OP_ADDI, OP_AND, OP_ANDI,
        OP_JMP, OP_CALL, OP_RET, OP_RETA, OP_RETI, OP_MOVPCL,
        OP_CLR, OP_CLRB, OP_CPL, OP_DAA, OP_DEC, OP_INC,
        OP_SZ, OP_SZB, OP_SNZB, OP_SIZ, OP_SDZ, OP_SWAP,
        OP_WDTC, OP_WDT1, OP_WDT2, OP_HALT,
        OP_TRD_SPEC, OP_TRD_CUR, OP_TRD_LAST
    } mie_op_e;

    // One decoded instruction
    typedef struct packed {
        mie_op_e op;
        logic to_acc;
        logic [6:0] addr;
        logic [7:0] imm;
        logic [2:0] bitsel;
        logic [10:0] target;
    } mie_instr_s;

    // Status flags
    typedef struct packed {
        logic power_down_flag;
        logic to;
        logic ov;
        logic z;
        logic ac;
        logic c;
    } mie_flags_s;

    // Execution states
    typedef enum logic [1:0] {
        ST_EXEC, ST_DUMMY, ST_HALT
    } mie_state_e;

endpackage

// ### hw/mie_core.sv
`timescale 1ns/100ps
// Behaviour
// RULE_01: Skip instructions take two cycles when skipping, one otherwise.
// RULE_02: Writing the program counter low byte takes two cycles.
// RULE_03: Preclear pair clears watchdog and both flags only when consecutive.
// RULE_04: Single watchdog clear clears counter, timeout and power-down flags.
// RULE_05: Add with carry sums acc, byte, carry; sets ov, z, ac, c.
// RULE_06: Add sums acc with byte or immediate; sets ov, z, ac, c.
// RULE_07: AND acc with byte or immediate; only zero flag changes.
// RULE_08: Call pushes program counter plus one, loads target, two cycles.
// RULE_09: Byte clear writes zero, bit clear zeroes one bit, no flags.
// RULE_10: Complement inverts byte, sets zero; acc form leaves memory.
// RULE_11: Decimal adjust adds six per nibble, result to memory, carry only.
// RULE_12: Decrement subtracts one, zero flag only; acc form leaves memory.
// RULE_13: Increment adds one, zero flag only; acc form leaves memory.
// RULE_14: Power-down stops, gates clock, clears watchdog, sets pdf, clears timeout.
// RULE_15: Table reads fetch page word, high to table register, low to memory.
// RULE_16: Jump, call and returns take two cycles, flags untouched.
// RULE_17: Skip family tests byte or bit; acc forms keep memory; no flags.
// RULE_18: Swap exchanges nibbles; acc form to acc; no-op is one cycle.
// RULE_19: Return from interrupt pops program counter and sets interrupt enable.
// RULE_20: Flags follow usual 8-bit carry, half carry, zero, overflow meaning.
module mie_core
    import mie_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Instruction issue
    input wire logic i_instr_valid,
    input wire mie_pkg::mie_instr_s i_instr,
    output logic o_instr_ready,
    output logic [mie_pkg::PC_W-1:0] o_pc,
    // Program memory table port, combinational answer
    output logic [mie_pkg::PC_W-1:0] o_pm_addr,
    input wire logic [mie_pkg::PM_W-1:0] i_pm_data,
    // Watchdog, clock control and interrupt enable
    input wire logic i_wdt_timeout,
    input wire logic i_wake,
    output logic o_wdt_clear,
    output logic o_wdt_prescaler_clear,
    output logic o_clock_off,
    output logic o_global_interrupt_enable,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);
    import mie_pkg::*;

    mie_state_e state_reg;
    mie_flags_s flags_reg;
    logic [7:0] acc_reg;
    logic [PC_W-1:0] pc_reg;
    logic [7:0] table_read_high_byte_reg;
    logic gie_reg;
    logic [7:0] dmem [0:(1<<DMEM_ADDR_W)-1];
    logic [PC_W-1:0] stack [0:STACK_DEPTH-1];
    logic [1:0] sp_reg;
    logic last_wdt1_reg;
    logic last_wdt2_reg;
    logic [6:0] trd_addr_reg;
    logic trd_pending_reg;
    logic wake_s1_reg;
    logic wake_s2_reg;

    // Decode and datapath
    logic fire;
    mie_op_e op;
    logic [7:0] mval;
    logic [7:0] opb;
    logic cin;
    logic [8:0] sum9;
    logic [4:0] sum_lo;
    logic [7:0] alu_res;
    logic res_zero;
    logic skip;
    logic two_cycle;
    logic [7:0] daa_res;
    logic daa_lo;
    logic daa_hi;
    logic wdt_full_clear;

    assign fire = (state_reg == ST_EXEC) && i_instr_valid;
    assign op = i_instr.op;
    assign mval = dmem[i_instr.addr];
    assign o_instr_ready = (state_reg == ST_EXEC);
    assign o_pc = pc_reg;
    assign o_clock_off = (state_reg == ST_HALT);
    assign o_global_interrupt_enable = gie_reg;

    // Shared adder
    // RULE_05 carry in
    always_comb
    begin
        opb = (op == OP_ADDI) ? i_instr.imm : mval;
        cin = (op == OP_ADC) ? flags_reg.c : 1'b0;
        // RULE_20 flag arithmetic
        sum9 = {1'b0, acc_reg} + {1'b0, opb} + {8'h00, cin};
        sum_lo = {1'b0, acc_reg[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
    end

    // Decimal adjust of the accumulator
    // RULE_11 nibble correction
    always_comb
    begin
        daa_lo = (acc_reg[3:0] > BCD_LIMIT) || flags_reg.ac;
        daa_hi = (acc_reg[7:4] > BCD_LIMIT) || flags_reg.c;
        daa_res = acc_reg + {(daa_hi ? BCD_ADJ : 4'h0), (daa_lo ? BCD_ADJ : 4'h0)};
    end

    // Result of the byte operations
    always_comb
    begin
        unique case (op)
            OP_ADD, OP_ADC, OP_ADDI: alu_res = sum9[7:0];
            // RULE_07 bitwise and
            OP_AND: alu_res = acc_reg & mval;
            OP_ANDI: alu_res = acc_reg & i_instr.imm;
            OP_CLR: alu_res = 8'h00;
            OP_CLRB: alu_res = mval & ~(8'h01 << i_instr.bitsel);
            OP_CPL: alu_res = ~mval;
            OP_DAA: alu_res = daa_res;
            OP_DEC, OP_SDZ: alu_res = mval - 8'h01;
            OP_INC, OP_SIZ: alu_res = mval + 8'h01;
            OP_SWAP: alu_res = {mval[3:0], mval[7:4]};
            default: alu_res = mval;
        endcase
        res_zero = (alu_res == 8'h00);
    end

    // Skip decision and cycle count
    always_comb
    begin
        // RULE_17 skip tests
        unique case (op)
            OP_SZ, OP_SIZ, OP_SDZ: skip = res_zero;
            OP_SZB: skip = ~mval[i_instr.bitsel];
            OP_SNZB: skip = mval[i_instr.bitsel];
            default: skip = 1'b0;
        endcase
        // RULE_01 skip costs a dummy cycle
        // RULE_02 program counter low write
        // RULE_16 branch timing
        // RULE_15 table read timing
        two_cycle = skip || (op inside {OP_JMP, OP_CALL, OP_RET, OP_RETA, OP_RETI,
                    OP_MOVPCL, OP_TRD_SPEC, OP_TRD_CUR, OP_TRD_LAST});
    end

    // Execution sequencing; halt waits for a synchronised wake
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            state_reg <= ST_EXEC;
        else
        begin
            unique case (state_reg)
                ST_EXEC:
                    if (fire && op == OP_HALT)
                        state_reg <= ST_HALT;
                    else if (fire && two_cycle)
                        state_reg <= ST_DUMMY;
                ST_DUMMY: state_reg <= ST_EXEC;
                ST_HALT:
                    if (wake_s2_reg)
                        state_reg <= ST_EXEC;
            endcase
        end
    end

    // Wake pin synchroniser
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            wake_s1_reg <= 1'b0;
            wake_s2_reg <= 1'b0;
        end
        else
        begin
            wake_s1_reg <= i_wake;
            wake_s2_reg <= wake_s1_reg;
        end
    end

    // Program counter and return stack
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            pc_reg <= RST_PC;
            sp_reg <= 2'd0;
        end
        else if (fire)
        begin
            unique case (op)
                // RULE_16 jump
                OP_JMP: pc_reg <= i_instr.target;
                OP_CALL:
                begin
                    // RULE_08 push return address
                    stack[sp_reg] <= pc_reg + 11'd1;
                    sp_reg <= sp_reg + 2'd1;
                    pc_reg <= i_instr.target;
                end
                OP_RET, OP_RETA, OP_RETI:
                begin
                    // RULE_19 restore from stack
                    pc_reg <= stack[sp_reg - 2'd1];
                    sp_reg <= sp_reg - 2'd1;
                end
                OP_MOVPCL: pc_reg <= {pc_reg[10:8], acc_reg};
                default: pc_reg <= pc_reg + (skip ? 11'd2 : 11'd1);
            endcase
        end
    end

    // Accumulator
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            acc_reg <= RST_ACC;
        else if (fire)
        begin
            if (op inside {OP_ADDI, OP_ANDI})
                acc_reg <= alu_res;
            else if (op == OP_RETA)
                acc_reg <= i_instr.imm;
            // RULE_10 acc form complement
            // RULE_12 acc form decrement
            // RULE_13 acc form increment
            // RULE_18 acc form swap
            else if (i_instr.to_acc && (op inside {OP_ADD, OP_ADC, OP_AND, OP_CPL, OP_DEC, OP_INC,
                     OP_SZ, OP_SIZ, OP_SDZ, OP_SWAP}))
                acc_reg <= alu_res;
        end
    end

    // Data memory, not reset: power-down retains it
    always_ff @(posedge i_clk)
    begin
        // RULE_15 low byte to memory
        if (state_reg == ST_DUMMY && trd_pending_reg)
            dmem[trd_addr_reg] <= i_pm_data[7:0];
        else if (fire && !i_reset)
        begin
            // RULE_09 clears
            // RULE_11 result to memory
            if (op inside {OP_CLR, OP_CLRB, OP_DAA}
                || (!i_instr.to_acc && (op inside {OP_ADD, OP_ADC, OP_AND, OP_CPL,
                    OP_DEC, OP_INC, OP_SIZ, OP_SDZ, OP_SWAP})))
                dmem[i_instr.addr] <= alu_res;
        end
    end

    // Table read address and high byte
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            trd_pending_reg <= 1'b0;
            trd_addr_reg <= 7'h00;
            table_read_high_byte_reg <= 8'h00;
            o_pm_addr <= RST_PC;
        end
        else if (fire && (op inside {OP_TRD_SPEC, OP_TRD_CUR, OP_TRD_LAST}))
        begin
            trd_pending_reg <= 1'b1;
            trd_addr_reg <= i_instr.addr;
            unique case (op)
                OP_TRD_SPEC: o_pm_addr <= {i_instr.target[10:8], acc_reg};
                OP_TRD_CUR: o_pm_addr <= {pc_reg[10:8], acc_reg};
                default: o_pm_addr <= {LAST_PAGE, acc_reg};
            endcase
        end
        else if (state_reg == ST_DUMMY && trd_pending_reg)
        begin
            // RULE_15 high byte to table register
            table_read_high_byte_reg <= i_pm_data[15:8];
            trd_pending_reg <= 1'b0;
        end
    end

    // Preclear pairing, previous op only
    // RULE_03 consecutive pair
    assign wdt_full_clear = fire && ((op == OP_WDTC)
        || (op == OP_WDT2 && last_wdt1_reg) || (op == OP_WDT1 && last_wdt2_reg));
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            last_wdt1_reg <= 1'b0;
            last_wdt2_reg <= 1'b0;
        end
        else if (fire)
        begin
            last_wdt1_reg <= (op == OP_WDT1) && !last_wdt2_reg;
            last_wdt2_reg <= (op == OP_WDT2) && !last_wdt1_reg;
        end
    end

    // Watchdog strobes, one cycle late
    // RULE_04 single clear
    // RULE_14 halt clears watchdog and prescaler
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_wdt_clear <= 1'b0;
            o_wdt_prescaler_clear <= 1'b0;
        end
        else
        begin
            o_wdt_clear <= wdt_full_clear || (fire && op == OP_HALT);
            o_wdt_prescaler_clear <= fire && op == OP_HALT;
        end
    end

    // All flags in one process; a timeout wins over a clear
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            flags_reg <= '0;
        else
        begin
            // RULE_06 add flags
            if (fire && op inside {OP_ADD, OP_ADC, OP_ADDI})
            begin
                flags_reg.c <= sum9[8];
                flags_reg.ac <= sum_lo[4];
                flags_reg.ov <= (acc_reg[7] == opb[7]) && (sum9[7] != acc_reg[7]);
                flags_reg.z <= res_zero;
            end
            // RULE_07 zero only
            else if (fire && op inside {OP_AND, OP_ANDI, OP_CPL, OP_DEC, OP_INC})
                flags_reg.z <= res_zero;
            // RULE_11 carry only, sticky for multi-byte sums
            else if (fire && op == OP_DAA)
                flags_reg.c <= flags_reg.c | daa_hi;
            if (i_wdt_timeout)
                flags_reg.to <= 1'b1;
            else if (wdt_full_clear || (fire && op == OP_HALT))
                flags_reg.to <= 1'b0;
            // RULE_14 power-down flag
            if (fire && op == OP_HALT)
                flags_reg.power_down_flag <= 1'b1;
            else if (wdt_full_clear)
                flags_reg.power_down_flag <= 1'b0;
        end
    end

    // Global interrupt enable; hardware set beats a software clear
    logic ahb_wr_reg;
    logic [7:0] ahb_addr_reg;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            gie_reg <= RST_GIE;
        // RULE_19 re-enable interrupts
        else if (fire && op == OP_RETI)
            gie_reg <= 1'b1;
        else if (ahb_wr_reg && ahb_addr_reg == OFS_CTRL)
            gie_reg <= i_hwdata[CTRL_GIE_BIT];
    end

    // Bus address phase capture; zero wait states, always OKAY
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ahb_wr_reg <= 1'b0;
            ahb_addr_reg <= 8'h00;
        end
        else if (i_hready)
        begin
            ahb_wr_reg <= i_hsel && i_htrans[1] && i_hwrite;
            ahb_addr_reg <= i_haddr[7:0];
        end
    end
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;

    // Registered read data
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_hrdata <= 32'h0000_0000;
        else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
        begin
            unique case (i_haddr[7:0])
                OFS_CTRL: o_hrdata <= {31'h0, gie_reg};
                OFS_STATUS: o_hrdata <= {23'h0, state_reg == ST_HALT, 2'b00, flags_reg};
                OFS_ACC: o_hrdata <= {24'h0, acc_reg};
                OFS_PC: o_hrdata <= {21'h0, pc_reg};
                OFS_TABLE_READ_HIGH_BYTE: o_hrdata <= {24'h0, table_read_high_byte_reg};
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    sequence s_skip_taken;
        fire && skip;
    endsequence
    chk_skip_two_cycles: assert property (@(posedge i_clk) disable iff (i_reset)
        s_skip_taken |=> !o_instr_ready ##1 o_instr_ready) // RULE_01
        else $error("taken skip not two cycles");
    chk_noskip_one: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_SZ && !skip |=> o_instr_ready) // RULE_01
        else $error("untaken skip stalled");
    chk_pcl_two: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_MOVPCL |=> !o_instr_ready) // RULE_02
        else $error("pc low write not two cycles");
    chk_wdt_repeat: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_WDT1 && !last_wdt2_reg |=> !o_wdt_clear) // RULE_03
        else $error("lone preclear cleared watchdog");
    chk_wdt_single: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_WDTC && !i_wdt_timeout |=> o_wdt_clear && !flags_reg.to
        && !flags_reg.power_down_flag) // RULE_04
        else $error("watchdog clear incomplete");
    chk_add_carry: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_ADC && i_instr.to_acc |=> flags_reg.c == $past(sum9[8])
        && acc_reg == $past(sum9[7:0])) // RULE_05
        else $error("add with carry wrong");
    chk_call_push: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_CALL |=> pc_reg == $past(i_instr.target)
        && stack[sp_reg - 2'd1] == $past(pc_reg) + 11'd1 ##1 o_instr_ready) // RULE_08
        else $error("call push wrong");
    chk_halt_flags: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_HALT && !i_wdt_timeout |=> o_clock_off && flags_reg.power_down_flag
        && !flags_reg.to && o_wdt_prescaler_clear) // RULE_14
        else $error("halt effects wrong");
    chk_branch_flags: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op inside {OP_JMP, OP_RET, OP_RETI} |=> $stable(flags_reg.c)
        && $stable(flags_reg.z) && !o_instr_ready) // RULE_16
        else $error("branch touched flags");
    chk_reti_gie: assert property (@(posedge i_clk) disable iff (i_reset)
        fire && op == OP_RETI |=> o_global_interrupt_enable) // RULE_19
        else $error("return from interrupt left disabled");
    chk_tbl_high: assert property (@(posedge i_clk) disable iff (i_reset)
        state_reg == ST_DUMMY && trd_pending_reg |=> table_read_high_byte_reg == $past(i_pm_data[15:8])) // RULE_15
        else $error("table high byte wrong");
endmodule

// ### bench/mie_partner.sv
`timescale 1ns/100ps
// Program memory and watchdog stand-in
module mie_partner
    import mie_pkg::*;
(
    // Clock
    input wire logic i_clk,
    // Table fetch and watchdog request
    input wire logic [mie_pkg::PC_W-1:0] i_pm_addr,
    input wire logic i_fire,
    output logic [mie_pkg::PM_W-1:0] o_pm_data,
    output logic o_wdt_timeout
);
    // Word follows the address, so a wrong page shows up
    assign o_pm_data = {5'h0b, i_pm_addr[10:8], i_pm_addr[7:0] ^ 8'h5a};
    // Timeout pulse one cycle after the request
    initial o_wdt_timeout = 1'b0;
    always @(posedge i_clk) o_wdt_timeout <= i_fire;
endmodule

// ### bench/testbench.sv
`timescale 1ns/100ps
// Directed and random instruction streams against a reference model
module testbench;
    import mie_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic valid = 1'b0;
    logic wake = 1'b0;
    logic fire = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    mie_instr_s ins = '0;
    logic ready, coff, wclr, pclr, gie, tmo, hrdy, hresp;
    logic [10:0] pc, pma;
    logic [15:0] pmd;
    logic [31:0] hrdata, bad_count = 0, check_count = 0;
    logic [31:0] dum_n = 0, wclr_n = 0, pclr_n = 0, m_dum = 0, m_wclr = 0;
    // Reference model state
    logic [7:0] mem [8];
    logic [7:0] m_acc = 8'h0;
    logic [7:0] m_tbl = 8'h0;
    mie_flags_s m_fl = '0;
    logic [10:0] m_pc = 11'h0;
    logic [10:0] stk [4];
    logic [1:0] sp = 2'h0;
    logic [1:0] prev = 2'h0;

    always #2 clk = ~clk;
    // Event counters
    always @(posedge clk)
    begin
        dum_n <= dum_n + 32'(!rst && ready === 1'b0 && coff === 1'b0);
        wclr_n <= wclr_n + 32'(wclr === 1'b1);
        pclr_n <= pclr_n + 32'(pclr === 1'b1);
    end

    mie_core mie_core_inst (.i_clk(clk), .i_reset(rst), .i_instr_valid(valid), .i_instr(ins),
        .o_instr_ready(ready), .o_pc(pc), .o_pm_addr(pma), .i_pm_data(pmd),
        .i_wdt_timeout(tmo), .i_wake(wake), .o_wdt_clear(wclr), .o_wdt_prescaler_clear(pclr),
        .o_clock_off(coff), .o_global_interrupt_enable(gie), .i_hsel(1'b1), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .o_hrdata(hrdata));
    mie_partner mie_partner_inst (.i_clk(clk), .i_pm_addr(pma), .i_fire(fire),
        .o_pm_data(pmd), .o_wdt_timeout(tmo));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask

    // One AHB transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        cmp(r, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    function automatic mie_instr_s mk(mie_op_e op, logic ta, logic [7:0] v, logic [10:0] tg);
        mk = '{op: op, to_acc: ta, addr: {4'h0, v[2:0]}, imm: v, bitsel: v[5:3], target: tg};
    endfunction

    // Expected effect of one taken instruction
    function automatic void step(input mie_instr_s x);
        logic [7:0] m, s, r;
        logic [4:0] h;
        logic [10:0] p;
        logic c0, hi, sk, t;
        m = mem[x.addr[2:0]];
        s = (x.op inside {OP_ADDI, OP_ANDI}) ? x.imm : m;
        c0 = (x.op == OP_ADC) & m_fl.c;
        p = m_pc;
        m_pc = p + 11'h1;
        r = m;
        t = x.op inside {OP_TRD_SPEC, OP_TRD_CUR, OP_TRD_LAST};
        hi = m_acc[7:4] > 4'h9 || m_fl.c;
        if (!(x.op inside {OP_WDT1, OP_WDT2}))
            prev = 2'h0;
        case (x.op)
            OP_ADD, OP_ADC, OP_ADDI:
            begin
                {m_fl.c, r} = {1'b0, m_acc} + {1'b0, s} + {8'h0, c0};
                h = {1'b0, m_acc[3:0]} + {1'b0, s[3:0]} + {4'h0, c0};
                m_fl.ac = h[4];
                m_fl.ov = m_acc[7] == s[7] && r[7] != s[7];
            end
            OP_AND, OP_ANDI: r = m_acc & s;
            OP_CPL: r = ~m;
            OP_DEC, OP_SDZ: r = m - 8'h1;
            OP_INC, OP_SIZ: r = m + 8'h1;
            OP_CLR: r = 8'h0;
            OP_CLRB: r = m & ~(8'h1 << x.bitsel);
            OP_SWAP: r = {m[3:0], m[7:4]};
            OP_DAA:
            begin
                r = m_acc + {hi ? 4'h6 : 4'h0, (m_acc[3:0] > 4'h9 || m_fl.ac) ? 4'h6 : 4'h0};
                m_fl.c = m_fl.c | hi;
            end
            OP_TRD_SPEC, OP_TRD_CUR, OP_TRD_LAST:
            begin
                r = m_acc ^ 8'h5a;
                m_tbl = {5'h0b, x.op == OP_TRD_SPEC ? x.target[10:8] :
                    x.op == OP_TRD_CUR ? p[10:8] : 3'h7};
            end
            OP_JMP: m_pc = x.target;
            OP_CALL:
            begin
                stk[sp] = m_pc;
                sp = sp + 2'h1;
                m_pc = x.target;
            end
            OP_RET, OP_RETA, OP_RETI:
            begin
                sp = sp - 2'h1;
                m_pc = stk[sp];
                if (x.op == OP_RETA)
                    m_acc = x.imm;
            end
            OP_MOVPCL: m_pc = {p[10:8], m_acc};
            OP_WDTC, OP_HALT:
            begin
                m_fl.to = 1'b0;
                m_fl.power_down_flag = x.op == OP_HALT;
                m_wclr++;
            end
            OP_WDT1, OP_WDT2:
            begin
                if (prev == (x.op == OP_WDT1 ? 2'h2 : 2'h1))
                begin
                    {m_fl.power_down_flag, m_fl.to} = 2'h0;
                    m_wclr++;
                    prev = 2'h0;
                end
                else
                    prev = (x.op == OP_WDT1) ? 2'h1 : 2'h2;
            end
            default: ;
        endcase
        sk = (x.op inside {OP_SZ, OP_SIZ, OP_SDZ} && r == 8'h0) ||
            (x.op == OP_SZB && !m[x.bitsel]) || (x.op == OP_SNZB && m[x.bitsel]);
        if (sk)
            m_pc = m_pc + 11'h1;
        if (sk || t || x.op inside {OP_JMP, OP_CALL, OP_RET, OP_RETA, OP_RETI, OP_MOVPCL})
            m_dum++;
        if (x.op inside {OP_ADD, OP_ADC, OP_ADDI, OP_AND, OP_ANDI, OP_CPL, OP_DEC, OP_INC})
            m_fl.z = r == 8'h0;
        if (x.op inside {OP_ADDI, OP_ANDI} || (x.to_acc && x.op inside {OP_ADD, OP_ADC, OP_AND,
            OP_CPL, OP_DEC, OP_INC, OP_SWAP, OP_SZ, OP_SIZ, OP_SDZ}))
            m_acc = r;
        else if (t || x.op inside {OP_CLR, OP_CLRB, OP_DAA, OP_ADD, OP_ADC, OP_AND, OP_CPL,
            OP_DEC, OP_INC, OP_SWAP, OP_SIZ, OP_SDZ})
            mem[x.addr[2:0]] = r;
    endfunction

    // Offer held until taken
    task automatic run(input mie_instr_s x);
        valid <= 1'b1;
        ins <= x;
        @(posedge clk);
        while (ready !== 1'b1) @(posedge clk);
        step(x);
    endtask

    task automatic run1(input mie_op_e o);
        run(mk(o, 1'b0, 8'h0, 11'h0));
    endtask

    task automatic tick();
        valid <= 1'b0;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (2) @(posedge clk);
        m_fl.to = 1'b1;
    endtask

    task automatic check_all();
        valid <= 1'b0;
        rd(OFS_ACC, {24'h0, m_acc});
        rd(OFS_STATUS, {26'h0, m_fl});
        cmp({21'h0, pc}, {21'h0, m_pc});
        cmp(dum_n, m_dum);
        cmp(wclr_n, m_wclr);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count != 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #40000;
        bad_count++;
        close_out();
    end

    initial
    begin
        mie_instr_s x;
        mie_instr_s dl [$];
        void'($urandom(32'h53b78507));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(OFS_STATUS, 32'h0);
        rd(OFS_PC, 32'h0);
        rd(8'h40, 32'h0);
        for (int i = 0; i < 8; i++)
            run(mk(OP_CLR, 1'b0, 8'(i), 11'h0));
        dl = '{mk(OP_SZ, 1'b0, 8'h00, 11'h0), mk(OP_SIZ, 1'b1, 8'h01, 11'h0),
            mk(OP_JMP, 1'b0, 8'h0, 11'h0fe), mk(OP_ADDI, 1'b0, 8'hf7, 11'h0),
            mk(OP_MOVPCL, 1'b0, 8'h0, 11'h0), mk(OP_CALL, 1'b0, 8'h0, 11'h3f0),
            mk(OP_CALL, 1'b0, 8'h0, 11'h120), mk(OP_RETA, 1'b0, 8'h81, 11'h0),
            mk(OP_RET, 1'b0, 8'h0, 11'h0), mk(OP_TRD_SPEC, 1'b0, 8'h02, 11'h5ff),
            mk(OP_TRD_CUR, 1'b0, 8'h03, 11'h0), mk(OP_TRD_LAST, 1'b0, 8'h04, 11'h0),
            mk(OP_CALL, 1'b0, 8'h0, 11'h200), mk(OP_RETI, 1'b0, 8'h0, 11'h0)};
        foreach (dl[i])
        begin
            run(dl[i]);
            check_all();
        end
        rd(OFS_TABLE_READ_HIGH_BYTE, {24'h0, m_tbl});
        rd(OFS_CTRL, 32'h1);
        tick();
        run1(OP_WDT1);
        run1(OP_NOP);
        run1(OP_WDT2);
        check_all();
        run1(OP_WDT2);
        run1(OP_WDT1);
        run1(OP_WDT2);
        check_all();
        tick();
        run1(OP_WDTC);
        check_all();
        run1(OP_HALT);
        valid <= 1'b0;
        repeat (4) @(posedge clk);
        cmp({31'h0, coff}, 32'h1);
        wake <= 1'b1;
        repeat (4) @(posedge clk);
        cmp({31'h0, coff}, 32'h0);
        wake <= 1'b0;
        check_all();
        cmp(pclr_n, 32'h1);
        repeat (200)
        begin
            x = mk(mie_op_e'(6'($urandom_range(30))), 1'($urandom), 8'($urandom),
                11'($urandom));
            if (x.op inside {OP_RET, OP_RETA, OP_RETI, OP_HALT})
                x.op = OP_NOP;
            if ($urandom_range(7) == 0)
                tick();
            run(x);
            if ($urandom_range(1) == 0)
                check_all();
        end
        check_all();
        wr(OFS_TABLE_READ_HIGH_BYTE, 32'hff);
        rd(OFS_TABLE_READ_HIGH_BYTE, {24'h0, m_tbl});
        wr(OFS_CTRL, 32'h0);
        rd(OFS_CTRL, 32'h0);
        cmp({31'h0, gie}, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        close_out();
    end
endmodule
